// >>> common/cpu_pkg.sv
package cpu_pkg;
    // system prescaler geometry
    localparam int          SYS_WIDTH      = 13;
    localparam logic [12:0] SYS_RESET_VAL  = 13'h0000;
    // watch prescaler geometry
    localparam int          WATCH_WIDTH    = 5;
    localparam logic [4:0]  WATCH_RESET_VAL = 5'h00;
    localparam int          WATCH_PRE_DIV  = 4;
    localparam int          WATCH_PRE_W    = 2;
    // medium-speed ratio codes: osc/16, /32, /64, /128
    localparam logic [1:0]  MED_DIV16      = 2'h0;
    localparam logic [1:0]  MED_DIV32      = 2'h1;
    localparam logic [1:0]  MED_DIV64      = 2'h2;
    localparam logic [1:0]  MED_DIV128     = 2'h3;
    localparam int          MED_DIV_W      = 7;
    // timekeeping timer clock-select value that clears the watch prescaler
    localparam logic [1:0]  TK_SEL_CLEAR   = 2'h3;
    // port mode register two: subclock source select bit position
    localparam int          PORT_MODE_SRC_BIT = 7;

    // operating modes of the chip
    typedef enum logic [2:0] {
        CPU_MODE_ACTIVE_HS,
        CPU_MODE_ACTIVE_MS,
        CPU_MODE_SLEEP,
        CPU_MODE_STANDBY,
        CPU_MODE_WATCH,
        CPU_MODE_SUBACTIVE,
        CPU_MODE_SUBSLEEP
    } cpu_mode_t;
endpackage : cpu_pkg

// >>> core/cpu_watch_prescaler.sv
`timescale 1ns/10ps
// ==========================================================================
// watch prescaler: divide-by-four stage then a 5-bit counter
// ==========================================================================
module cpu_watch_prescaler
    import cpu_pkg::*;
#(
    parameter int WIDTH = WATCH_WIDTH
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_srst,
    input  wire logic             i_watch_tick,
    input  wire logic             i_clear,
    output logic [WIDTH-1:0]      o_count,
    output logic [WIDTH+1:0]      o_taps
);
    logic [WATCH_PRE_W-1:0] pre_r;
    logic [WIDTH-1:0]       cnt_r;

    // refused at elaboration: count plus pre stage must fit the tap bus
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
        $error("watch prescaler width unsupported");
    end

    // divide watch clock by four; the counter advances on pre wrap
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || i_clear) begin
            pre_r <= '0;
        end else if (i_watch_tick) begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // count keeps running in any power mode while subclock ticks arrive
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt_r <= WIDTH'(WATCH_RESET_VAL);
        end else if (i_clear) begin
            cnt_r <= '0;
        end else if (i_watch_tick && (&pre_r)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign o_count = cnt_r;
    // taps: /2, /4 from pre stage, /8../128 from counter bits
    assign o_taps  = {cnt_r, pre_r};
endmodule : cpu_watch_prescaler

// >>> core/cpu_prescaler_top.sv
`timescale 1ns/10ps
module cpu_prescaler_top
    import cpu_pkg::*;
#(
    parameter int NUM_PERIPH = 4
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_srst,
    input  wire logic [2:0]                    i_mode,
    input  wire logic [1:0]                    i_med_ratio,
    input  wire logic [7:0]                    i_port_mode_reg_two,
    input  wire logic                          i_timekeeping_clock_sel_hi,
    input  wire logic                          i_timekeeping_clock_sel_lo,
    input  wire logic                          i_subclock_resonator_in,
    input  wire logic                          i_subclock_ext_in,
    input  wire logic [NUM_PERIPH*4-1:0]       i_periph_sel,
    output logic [SYS_WIDTH-1:0]               o_sys_taps,
    output logic [WATCH_WIDTH+2:0]             o_watch_taps,
    output logic [WATCH_WIDTH-1:0]             o_timekeeping_base,
    output logic [NUM_PERIPH-1:0]              o_periph_clk,
    output logic                               o_shared_port_pin_free,
    output logic                               o_sys_running
);
    // ======================================================================
    // elaboration checks
    // ======================================================================
    // refused at elaboration: the select bus is four bits per peripheral
    if (NUM_PERIPH < 1 || NUM_PERIPH > 16) begin : g_bad_periph
        $error("peripheral count bad");
    end

    // ======================================================================
    // mode decoding
    // ======================================================================
    cpu_mode_t mode;
    assign mode = cpu_mode_t'(i_mode);

    // system clock generator halts in these modes
    function automatic logic sys_halted(input cpu_mode_t m);
        case (m)
            CPU_MODE_STANDBY, CPU_MODE_WATCH,
            CPU_MODE_SUBACTIVE, CPU_MODE_SUBSLEEP: sys_halted = 1'b1;
            default:                               sys_halted = 1'b0;
        endcase
    endfunction : sys_halted

    logic halted;
    assign halted = sys_halted(mode);

    // ======================================================================
    // subclock source select and pin synchronisers
    // ======================================================================
    logic src_ext;
    assign src_ext = i_port_mode_reg_two[PORT_MODE_SRC_BIT];

    logic [1:0] res_sync_r;
    logic [1:0] ext_sync_r;
    logic       sub_prev_r;
    logic       sub_lvl;
    logic       watch_tick;

    // two flops on each asynchronous subclock pin
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            res_sync_r <= 2'h0;
            ext_sync_r <= 2'h0;
        end else begin
            res_sync_r <= {res_sync_r[0], i_subclock_resonator_in};
            ext_sync_r <= {ext_sync_r[0], i_subclock_ext_in};
        end
    end

    // 0 picks resonator, 1 picks external pin
    assign sub_lvl = src_ext ? ext_sync_r[1] : res_sync_r[1];

    // rising edge of the chosen subclock is one watch clock tick
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sub_prev_r <= 1'b0;
        end else begin
            sub_prev_r <= sub_lvl;
        end
    end
    assign watch_tick = sub_lvl & ~sub_prev_r;

    // shared pin is lost to the external clock function
    assign o_shared_port_pin_free = ~src_ext;

    // ======================================================================
    // medium-speed input divider
    // ======================================================================
    logic [MED_DIV_W-1:0] med_r;
    logic                 med_wrap;

    // free divider; only its wrap for the chosen ratio is used
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || halted || mode != CPU_MODE_ACTIVE_MS) begin
            med_r <= '0;
        end else begin
            med_r <= med_r + 1'b1;
        end
    end

    always_comb begin
        case (i_med_ratio)
            MED_DIV16:  med_wrap = &med_r[3:0];
            MED_DIV32:  med_wrap = &med_r[4:0];
            MED_DIV64:  med_wrap = &med_r[5:0];
            MED_DIV128: med_wrap = &med_r[6:0];
            default:    med_wrap = 1'b0;
        endcase
    end

    // ======================================================================
    // system prescaler
    // ======================================================================
    logic [SYS_WIDTH-1:0] sys_r;
    logic                 sys_step;

    // full rate in high speed, reduced rate in medium speed
    assign sys_step = (mode == CPU_MODE_ACTIVE_MS) ? med_wrap : 1'b1;

    // no processor port reaches this counter
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            sys_r <= SYS_RESET_VAL;
        end else if (halted) begin
            sys_r <= SYS_RESET_VAL;
        end else if (sys_step) begin
            sys_r <= sys_r + 1'b1;
        end
    end

    // bit k-1 toggles at input/2^k
    assign o_sys_taps    = sys_r;
    assign o_sys_running = ~halted;

    // ======================================================================
    // watch prescaler
    // ======================================================================
    logic [WATCH_WIDTH-1:0] watch_cnt;
    logic [WATCH_WIDTH+1:0] watch_div;
    logic                   watch_clear;

    assign watch_clear = ({i_timekeeping_clock_sel_hi,
                           i_timekeeping_clock_sel_lo} == TK_SEL_CLEAR);

    cpu_watch_prescaler #(
        .WIDTH        (WATCH_WIDTH)
    ) u_watch (
        .i_clk_sys    (i_clk_sys),
        .i_srst       (i_srst),
        .i_watch_tick (watch_tick),
        .i_clear      (watch_clear),
        .o_count      (watch_cnt),
        .o_taps       (watch_div)
    );

    // tap 0 is the watch clock itself, then /2 up to /128
    assign o_watch_taps       = {watch_div, sub_lvl};
    assign o_timekeeping_base = watch_cnt;

    // ======================================================================
    // per-peripheral tap selection
    // ======================================================================
    // each peripheral reads its own 4-bit code: tap index = code
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
            logic [3:0] sel;
            logic       clk_r;
            assign sel = i_periph_sel[gi*4 +: 4];
            // registered so a code change never glitches the output
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    clk_r <= 1'b0;
                end else if (sel < 4'(SYS_WIDTH)) begin
                    clk_r <= sys_r[sel];
                end else begin
                    clk_r <= 1'b0;
                end
            end
            assign o_periph_clk[gi] = clk_r;
        end
    endgenerate
endmodule : cpu_prescaler_top

// >>> sim/cpu_prescaler_chk.sv
`timescale 1ns/10ps
// ==========================================================
// prescaler port checker
module cpu_prescaler_chk
    import cpu_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_srst,
    input wire logic [2:0]  i_mode,
    input wire logic [7:0]  i_port_mode_reg_two,
    input wire logic        i_timekeeping_clock_sel_hi,
    input wire logic        i_timekeeping_clock_sel_lo,
    input wire logic [12:0] o_sys_taps,
    input wire logic [4:0]  o_timekeeping_base,
    input wire logic        o_shared_port_pin_free,
    input wire logic        o_sys_running
);
    // codes 3 to 6, above sleep, stop the system clock; this wire also flags unused code 7
    wire logic halted = i_mode > 3'h2;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    sys_step_a: assert property ($past(i_mode) == CPU_MODE_ACTIVE_HS
        && !$past(i_srst) |-> o_sys_taps == $past(o_sys_taps) + 13'h0001)
        else $error("count missed a step");
    med_step_a: assert property ($past(i_mode) == CPU_MODE_ACTIVE_MS
        |-> o_sys_taps - $past(o_sys_taps) <= 13'h0001)
        else $error("medium count jumped");
    sys_halt_a: assert property ($past(halted)
        |-> o_sys_taps == 13'h0000) else $error("count not held at zero");
    reset_clear_a: assert property ($fell(i_srst)
        |-> o_sys_taps == 13'h0000 && o_timekeeping_base == 5'h00)
        else $error("count not cleared by reset");
    run_flag_a: assert property (o_sys_running == !halted)
        else $error("running flag wrong");
    pin_free_a: assert property (o_shared_port_pin_free ==
        !i_port_mode_reg_two[7]) else $error("port pin flag wrong");
    watch_clear_a: assert property (i_timekeeping_clock_sel_hi &&
        i_timekeeping_clock_sel_lo |=> o_timekeeping_base == 5'h00)
        else $error("watch count not cleared");
    watch_step_a: assert property ($changed(o_timekeeping_base)
        |-> o_timekeeping_base == $past(o_timekeeping_base) + 5'h01
        || o_timekeeping_base == 5'h00) else $error("watch count jumped");
endmodule : cpu_prescaler_chk
bind cpu_prescaler_top cpu_prescaler_chk i_chk (.*);

// >>> sim/cpu_subclk_model.sv
`timescale 1ns/10ps
// ==========================================================
// subclock sources: resonator and external clock pin
module cpu_subclk_model (
    input  wire logic i_clk_sys,
    input  wire logic i_run_res,
    input  wire logic i_run_ext,
    output logic      o_res = 1'b0,
    output logic      o_ext = 1'b0
);
    logic [2:0] ph_r = 3'h0;
    // period of 8 system cycles; a stopped source idles low like a
    // grounded pin, so no stale level can pass for a clock
    always @(negedge i_clk_sys) begin
        ph_r  <= ph_r + 3'h1;
        o_res <= i_run_res & ph_r[2];
        o_ext <= i_run_ext & ph_r[2];
    end
endmodule : cpu_subclk_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// prescaler bench
module tb_top
    import cpu_pkg::*;
;
    logic        i_clk_sys = 1'b0, i_srst = 1'b1;
    logic        i_timekeeping_clock_sel_hi = 1'b0;
    logic        i_timekeeping_clock_sel_lo = 1'b0;
    logic        run_res = 1'b0, run_ext = 1'b0;
    logic        i_subclock_resonator_in, i_subclock_ext_in;
    logic        o_shared_port_pin_free, o_sys_running;
    logic [2:0]  i_mode = CPU_MODE_ACTIVE_HS;
    logic [1:0]  i_med_ratio = MED_DIV16;
    logic [7:0]  i_port_mode_reg_two = 8'h00, o_watch_taps;
    logic [15:0] i_periph_sel = 16'h3cf0;
    logic [12:0] o_sys_taps, c0;
    logic [4:0]  o_timekeeping_base, b0;
    logic [3:0]  o_periph_clk;
    int          bad_count = 0, comparisons = 0;
    cpu_prescaler_top i_dut (.*);
    cpu_subclk_model i_far (.i_clk_sys, .i_run_res(run_res),
        .i_run_ext(run_ext), .o_res(i_subclock_resonator_in),
        .o_ext(i_subclock_ext_in));
    // 100 MHz system clock
    always #5 i_clk_sys = ~i_clk_sys;
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : wait_cyc
    // case equality so an unknown never matches
    task automatic check(input string w, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) bad_count++;
        if (g !== e) $display("BAD %s expected %h seen %h", w, e, g);
    endtask : check
    task automatic test_done();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic t_reset_hs();
        i_srst = 1'b0;
        check("sys release", 16'h0000, 16'(o_sys_taps));
        wait_cyc(1);
        check("sys first", 16'h0001, 16'(o_sys_taps));
        wait_cyc(8192);
        check("sys wrap", 16'h0001, 16'(o_sys_taps));
        $display("done: reset and count");
    endtask : t_reset_hs
    // periph outputs lag the count by one edge; code 15 is out of range
    task automatic t_taps();
        logic [12:0] p;
        wait_cyc(4200);
        repeat (16) begin
            p = o_sys_taps - 13'h0001;
            check("periph", 16'({p[3], p[12], 1'b0, p[0]}),
                16'(o_periph_clk));
            wait_cyc(1);
        end
        $display("done: peripheral taps");
    endtask : t_taps
    task automatic t_low_power();
        run_res = 1'b1;
        for (int m = 3; m < 7; m++) begin
            i_mode = 3'(m);
            wait_cyc(40);
            b0 = o_timekeeping_base;
            wait_cyc(256);
            check("halted", 16'h0000, 16'(o_sys_taps));
            check("watch", 16'(5'(b0 + 5'h08)), 16'(o_timekeeping_base));
            check("watch taps", 16'(o_timekeeping_base),
                16'(o_watch_taps[7:3]));
        end
        $display("done: low power");
    endtask : t_low_power
    task automatic t_medium();
        i_mode = CPU_MODE_ACTIVE_MS;
        for (int r = 0; r < 4; r++) begin
            i_med_ratio = 2'(r);
            wait_cyc(32 << r);
            c0 = o_sys_taps;
            wait_cyc(64 << r);
            check("medium", 16'h0004, 16'(o_sys_taps - c0));
        end
        $display("done: medium speed");
    endtask : t_medium
    task automatic t_source();
        {i_timekeeping_clock_sel_hi, i_timekeeping_clock_sel_lo} = 2'h3;
        wait_cyc(4);
        check("cleared", 16'h0000, 16'(o_timekeeping_base));
        check("taps cleared", 16'h0000, 16'(o_watch_taps[7:1]));
        {i_timekeeping_clock_sel_hi, i_timekeeping_clock_sel_lo} = 2'h0;
        i_port_mode_reg_two = 8'h80;
        {run_res, run_ext} = 2'h1;
        wait_cyc(40);
        b0 = o_timekeeping_base;
        wait_cyc(256);
        check("ext", 16'(5'(b0 + 5'h08)), 16'(o_timekeeping_base));
        check("pin", 16'h0000, 16'(o_shared_port_pin_free));
        {run_res, run_ext} = 2'h2;
        wait_cyc(8);
        b0 = o_timekeeping_base;
        wait_cyc(256);
        check("res unused", 16'(b0), 16'(o_timekeeping_base));
        check("watch clk", 16'h0000, 16'(o_watch_taps[0]));
        $display("done: clear and source");
    endtask : t_source
    initial begin
        wait_cyc(4);
        t_reset_hs();
        t_taps();
        t_low_power();
        t_medium();
        t_source();
        test_done();
    end
    // the tests need about 16k cycles; a hang ends the run here
    initial begin
        wait_cyc(40000);
        bad_count++;
        test_done();
    end
endmodule : tb_top
